// ---- rbr_regs.sv ----
`include "rbr_params.svh"
`default_nettype none

module rbr_regs
  import rbr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in, // system clock, 100 mhz
  input wire logic srst_in, // sync reset, active high
  input wire logic ce_in, // clock enable, freezes state when low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction, high = write
  input wire logic [ADDR_W-1:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data, registered
  output logic pready_out, // apb ready, registered
  output logic pslverr_out // apb error on unmapped address
);

  // address must reach the highest offset and fit the request carrier
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
    $error("rbr_regs: ADDR_W must lie in 5..8");
  end

  rbr_apb_req_t req;
  rbr_sel_t sel;
  logic load;
  logic take;
  logic unlock_r;
  logic [1:0] tptr_r;
  logic [1:0] aptr_r;
  logic [2:0] tslot;
  logic [2:0] aslot;
  logic [7:0] time_slot_r [8];
  logic [7:0] alarm_slot_r [8];
  logic [31:0] rdata_nxt;
  logic wr_ok;
  logic wr_time;
  logic wr_alarm;

  // bundle the request so decode and write paths share one view
  assign req.addr = 8'(paddr_in);
  assign req.write = pwrite_in;
  assign req.wdata = pwdata_in;

  // address decode; misaligned or unknown offsets select nothing
  function automatic rbr_sel_t decode(input logic [7:0] addr);
    case (addr)
      `RBR_OFS_CTRL: decode = SEL_CTRL;
      `RBR_OFS_ALCFG: decode = SEL_ALCFG;
      `RBR_OFS_TIME_HI: decode = SEL_TIME_HI;
      `RBR_OFS_TIME_LO: decode = SEL_TIME_LO;
      `RBR_OFS_ALARM_HI: decode = SEL_ALARM_HI;
      `RBR_OFS_ALARM_LO: decode = SEL_ALARM_LO;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  // implemented bits of each time slot
  function automatic logic [7:0] time_mask(input logic [2:0] slot);
    case (slot)
      `RBR_SLOT_YEAR: time_mask = `RBR_MASK_YEAR;
      `RBR_SLOT_MONTH: time_mask = `RBR_MASK_MONTH;
      `RBR_SLOT_DAY: time_mask = `RBR_MASK_DAY;
      `RBR_SLOT_WEEKDAY_CODE: time_mask = `RBR_MASK_WEEKDAY_CODE;
      `RBR_SLOT_HOUR: time_mask = `RBR_MASK_HOUR;
      `RBR_SLOT_MIN: time_mask = `RBR_MASK_MINSEC;
      `RBR_SLOT_SEC: time_mask = `RBR_MASK_MINSEC;
      default: time_mask = `RBR_MASK_NONE;
    endcase
  endfunction : time_mask

  // alarm slots share layouts; pointer value three has no register
  function automatic logic [7:0] alarm_mask(input logic [2:0] slot);
    case (slot)
      `RBR_SLOT_MONTH: alarm_mask = `RBR_MASK_MONTH;
      `RBR_SLOT_DAY: alarm_mask = `RBR_MASK_DAY;
      `RBR_SLOT_WEEKDAY_CODE: alarm_mask = `RBR_MASK_WEEKDAY_CODE;
      `RBR_SLOT_HOUR: alarm_mask = `RBR_MASK_HOUR;
      `RBR_SLOT_MIN: alarm_mask = `RBR_MASK_MINSEC;
      `RBR_SLOT_SEC: alarm_mask = `RBR_MASK_MINSEC;
      default: alarm_mask = `RBR_MASK_NONE;
    endcase
  endfunction : alarm_mask

  // pointer steps down and parks at zero
  function automatic logic [1:0] ptr_step(input logic [1:0] ptr);
    ptr_step = (ptr == `RBR_PTR_FLOOR) ? `RBR_PTR_FLOOR : ptr - `RBR_PTR_STEP;
  endfunction : ptr_step

  rbr_apb_hs u_hs (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pready_out(pready_out),
    .load_out(load),
    .take_out(take)
  );

  assign sel = decode(req.addr);
  // the slot a transfer hits is fixed by its window and the pointer it finds
  assign tslot = {sel == SEL_TIME_HI, tptr_r};
  assign aslot = {sel == SEL_ALARM_HI, aptr_r};

  // write gating: every value slot needs the unlock bit
  assign wr_ok = ce_in && take && req.write && unlock_r;
  assign wr_time = wr_ok && (sel == SEL_TIME_HI || sel == SEL_TIME_LO);
  assign wr_alarm = wr_ok && (sel == SEL_ALARM_HI || sel == SEL_ALARM_LO);

  // control: unlock bit and time pointer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      unlock_r <= `RBR_UNLOCK_RESET;
      tptr_r <= `RBR_PTR_RESET;
    end else if (ce_in && take) begin
      if (sel == SEL_CTRL && req.write) begin
        unlock_r <= req.wdata[`RBR_UNLOCK_BIT];
        tptr_r <= req.wdata[`RBR_PTR_MSB:`RBR_PTR_LSB];
      end else if (sel == SEL_TIME_HI) begin
        // steps on reads and on refused writes alike
        tptr_r <= ptr_step(tptr_r);
      end
    end
  end

  // alarm pointer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aptr_r <= `RBR_PTR_RESET;
    end else if (ce_in && take) begin
      if (sel == SEL_ALCFG && req.write) begin
        aptr_r <= req.wdata[`RBR_PTR_MSB:`RBR_PTR_LSB];
      end else if (sel == SEL_ALARM_HI) begin
        aptr_r <= ptr_step(aptr_r);
      end
    end
  end

  // time values: no reset, contents stay unknown until written
  always_ff @(posedge clk_in) begin
    if (wr_time) begin
      time_slot_r[tslot] <= req.wdata[7:0] & time_mask(tslot);
    end
  end

  // alarm values: same treatment
  always_ff @(posedge clk_in) begin
    if (wr_alarm) begin
      alarm_slot_r[aslot] <= req.wdata[7:0] & alarm_mask(aslot);
    end
  end

  // read mux; masking again keeps empty slots at zero
  always_comb begin
    rdata_nxt = `RBR_DATA_ZERO;
    case (sel)
      SEL_CTRL: begin
        rdata_nxt[`RBR_UNLOCK_BIT] = unlock_r;
        rdata_nxt[`RBR_PTR_MSB:`RBR_PTR_LSB] = tptr_r;
      end
      SEL_ALCFG: begin
        rdata_nxt[`RBR_PTR_MSB:`RBR_PTR_LSB] = aptr_r;
      end
      SEL_TIME_HI, SEL_TIME_LO: begin
        rdata_nxt[7:0] = time_slot_r[tslot] & time_mask(tslot);
      end
      SEL_ALARM_HI, SEL_ALARM_LO: begin
        rdata_nxt[7:0] = alarm_slot_r[aslot] & alarm_mask(aslot);
      end
      default: begin
        rdata_nxt = `RBR_DATA_ZERO;
      end
    endcase
  end

  // answer captured on the same edge that raises pready
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prdata_out <= `RBR_DATA_ZERO;
      pslverr_out <= 1'b0;
    end else if (ce_in && load) begin
      prdata_out <= req.write ? `RBR_DATA_ZERO : rdata_nxt;
      pslverr_out <= (sel == SEL_NONE);
    end
  end

  default clocking rbr_cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence time_lo_wr(logic [1:0] p);
    ce_in && take && req.write && sel == SEL_TIME_LO && tptr_r == p;
  endsequence

  chk_reserved_zero: assert property (
    pready_out && !req.write && sel == SEL_TIME_HI && tptr_r == 2'h3
    |-> prdata_out == `RBR_DATA_ZERO)
    else $error("reserved slot read nonzero");

  chk_year_store: assert property (
    time_lo_wr(2'h3) and (unlock_r == 1'b1)
    |=> time_slot_r[`RBR_SLOT_YEAR] == $past(req.wdata[7:0]))
    else $error("year value not stored");

  chk_year_readback: assert property (
    ce_in && load && !req.write && sel == SEL_TIME_LO && tptr_r == 2'h3
    |=> prdata_out[7:0] == $past(time_slot_r[`RBR_SLOT_YEAR]))
    else $error("year readback mismatch");

  chk_year_locked: assert property (
    time_lo_wr(2'h3) and (unlock_r == 1'b0)
    |=> $stable(time_slot_r[`RBR_SLOT_YEAR]))
    else $error("locked year write took effect");

  chk_month_bits: assert property (
    ce_in && wr_time && tslot == `RBR_SLOT_MONTH
    |=> time_slot_r[`RBR_SLOT_MONTH] == {3'h0, $past(req.wdata[4:0])})
    else $error("month bits wrong");

  chk_day_bits: assert property (
    ce_in && wr_time && tslot == `RBR_SLOT_DAY
    |=> time_slot_r[`RBR_SLOT_DAY] == {2'h0, $past(req.wdata[5:0])})
    else $error("day bits wrong");

  chk_weekday_bits: assert property (
    ce_in && wr_time && tslot == `RBR_SLOT_WEEKDAY_CODE
    |=> time_slot_r[`RBR_SLOT_WEEKDAY_CODE] == {5'h00, $past(req.wdata[2:0])})
    else $error("weekday bits wrong");

  chk_hour_bits: assert property (
    ce_in && wr_time && tslot == `RBR_SLOT_HOUR
    |=> time_slot_r[`RBR_SLOT_HOUR] == {2'h0, $past(req.wdata[5:0])})
    else $error("hour bits wrong");

  chk_minute_bits: assert property (
    ce_in && wr_time && tslot == `RBR_SLOT_MIN
    |=> time_slot_r[`RBR_SLOT_MIN] == {1'b0, $past(req.wdata[6:0])})
    else $error("minute bits wrong");

  chk_second_bits: assert property (
    ce_in && wr_time && tslot == `RBR_SLOT_SEC
    |=> time_slot_r[`RBR_SLOT_SEC] == {1'b0, $past(req.wdata[6:0])})
    else $error("second bits wrong");

  chk_alarm_locked: assert property (
    ce_in && take && req.write && !unlock_r && sel == SEL_ALARM_LO
    |=> alarm_slot_r[$past(aslot)] == $past(alarm_slot_r[aslot]))
    else $error("locked alarm write took effect");

  chk_alarm_month: assert property (
    ce_in && wr_alarm && aslot == `RBR_SLOT_MONTH
    |=> alarm_slot_r[`RBR_SLOT_MONTH] == {3'h0, $past(req.wdata[4:0])})
    else $error("alarm month bits wrong");

  chk_alarm_day: assert property (
    ce_in && wr_alarm && aslot == `RBR_SLOT_DAY
    |=> alarm_slot_r[`RBR_SLOT_DAY] == {2'h0, $past(req.wdata[5:0])})
    else $error("alarm day bits wrong");

  chk_alarm_weekday: assert property (
    ce_in && wr_alarm && aslot == `RBR_SLOT_WEEKDAY_CODE
    |=> alarm_slot_r[`RBR_SLOT_WEEKDAY_CODE] == {5'h00, $past(req.wdata[2:0])})
    else $error("alarm weekday bits wrong");

  chk_alarm_hour: assert property (
    ce_in && wr_alarm && aslot == `RBR_SLOT_HOUR
    |=> alarm_slot_r[`RBR_SLOT_HOUR] == {2'h0, $past(req.wdata[5:0])})
    else $error("alarm hour bits wrong");

  chk_tptr_step: assert property (
    ce_in && take && sel == SEL_TIME_HI
    |=> ($past(tptr_r) == 2'h0) ? (tptr_r == 2'h0) : (tptr_r == 2'($past(tptr_r) - 2'h1)))
    else $error("time pointer did not step");

  chk_aptr_hold: assert property (
    ce_in && take && sel == SEL_ALARM_LO && !(srst_in)
    |=> $stable(aptr_r))
    else $error("alarm pointer moved on low access");

  chk_window_locked: assert property (
    ce_in && take && req.write && !unlock_r && sel == SEL_TIME_HI
    |=> time_slot_r[$past(tslot)] == $past(time_slot_r[tslot]))
    else $error("locked time window write took effect");

  chk_upper_zero: assert property (
    pready_out && sel != SEL_CTRL && sel != SEL_ALCFG
    |-> prdata_out[31:8] == 24'h00_0000)
    else $error("value read has upper bits set");

  cov_year_write: cover property (time_lo_wr(2'h3) and (unlock_r == 1'b1));
  cov_locked_write: cover property (ce_in && take && req.write && !unlock_r && wr_time == 1'b0
    && sel == SEL_TIME_LO);
  cov_ptr_walk: cover property (tptr_r == 2'h3 ##[1:40] tptr_r == 2'h0);
  cov_unmapped: cover property (pready_out && pslverr_out);

endmodule : rbr_regs

`default_nettype wire

// ---- rbr_params.svh ----
`ifndef RBR_PARAMS_SVH
`define RBR_PARAMS_SVH

// register byte offsets on the apb window
`define RBR_OFS_CTRL 8'h00
`define RBR_OFS_ALCFG 8'h04
`define RBR_OFS_TIME_HI 8'h08
`define RBR_OFS_TIME_LO 8'h0c
`define RBR_OFS_ALARM_HI 8'h10
`define RBR_OFS_ALARM_LO 8'h14

// control field positions, reset values and pointer step
`define RBR_UNLOCK_BIT 5
`define RBR_PTR_MSB 1
`define RBR_PTR_LSB 0
`define RBR_PTR_RESET 2'h0
`define RBR_PTR_FLOOR 2'h0
`define RBR_PTR_STEP 2'h1
`define RBR_UNLOCK_RESET 1'b0

// slot index is {high window, pointer}
`define RBR_SLOT_SEC 3'h0
`define RBR_SLOT_HOUR 3'h1
`define RBR_SLOT_DAY 3'h2
`define RBR_SLOT_YEAR 3'h3
`define RBR_SLOT_MIN 3'h4
`define RBR_SLOT_WEEKDAY_CODE 3'h5
`define RBR_SLOT_MONTH 3'h6
`define RBR_SLOT_RSVD 3'h7

// implemented bits of each value register
`define RBR_MASK_YEAR 8'hff
`define RBR_MASK_MONTH 8'h1f
`define RBR_MASK_DAY 8'h3f
`define RBR_MASK_WEEKDAY_CODE 8'h07
`define RBR_MASK_HOUR 8'h3f
`define RBR_MASK_MINSEC 8'h7f
`define RBR_MASK_NONE 8'h00

`define RBR_DATA_ZERO 32'h0000_0000

`endif

// ---- rbr_pkg.sv ----
`default_nettype none

package rbr_pkg;

  // decoded target of one apb transfer
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CTRL = 3'h1,
    SEL_ALCFG = 3'h2,
    SEL_TIME_HI = 3'h3,
    SEL_TIME_LO = 3'h4,
    SEL_ALARM_HI = 3'h5,
    SEL_ALARM_LO = 3'h6
  } rbr_sel_t;

  // handshake states, gray along idle -> answer -> idle
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_ANSWER = 2'b01
  } rbr_hs_state_t;

  // one apb request as seen by the register file
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } rbr_apb_req_t;

endpackage : rbr_pkg

`default_nettype wire

// ---- rbr_apb_hs.sv ----
`default_nettype none

module rbr_apb_hs
  import rbr_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic srst_in, // sync reset, active high
  input wire logic ce_in, // clock enable, freezes state when low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  output logic pready_out, // apb ready, registered
  output logic load_out, // first access cycle: capture answer
  output logic take_out // completing edge: commit effects
);

  rbr_hs_state_t state_r;
  rbr_hs_state_t state_nxt;
  logic access;

  assign access = psel_in && penable_in;
  // one wait state so read data can come from a flop
  assign load_out = access && (state_r == HS_IDLE);
  assign take_out = access && (state_r == HS_ANSWER);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HS_IDLE: begin
        if (access) begin
          state_nxt = HS_ANSWER;
        end
      end
      HS_ANSWER: begin
        state_nxt = HS_IDLE;
      end
      default: begin
        state_nxt = HS_IDLE;
      end
    endcase
  end

  // state and ready flop
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= HS_IDLE;
      pready_out <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      pready_out <= (state_nxt == HS_ANSWER);
    end
  end

  default clocking hs_cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  chk_ready_one_cycle: assert property (ce_in && pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  chk_ready_follows: assert property (ce_in && load_out |=> pready_out)
    else $error("pready did not follow access");

endmodule : rbr_apb_hs

`default_nettype wire

// ---- tb_rbr_regs.sv ----
`include "rbr_params.svh"
`default_nettype none

// one comparison, counted, mismatch reported at once
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb_rbr_regs
  import rbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] rdat;
  logic rerr;
  // implemented bits per slot, [window set][pointer]
  logic [7:0] mlo [2][4];
  logic [7:0] mhi [2][4];

  rbr_regs #(.ADDR_W(8)) dut_u (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out)
  );

  // 100 mhz system clock
  always #5 clk_in = ~clk_in;

  // verdict, reached from the main sequence or the watchdog
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // one apb transfer; request held until the rising edge that samples pready high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // right after the edge the outputs still show what stood before it
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      fail_count++;
      $display("[ERR] pready expected 1 seen timeout");
    end
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : xfer

  // select window set k at pointer p, unlock bit u
  task automatic sel(input int k, input logic [1:0] p, input logic u);
    xfer(1'b1, `RBR_OFS_CTRL, {26'h0, u, 3'h0, (k == 0) ? p : 2'h0});
    if (k == 1) begin
      xfer(1'b1, `RBR_OFS_ALCFG, {30'h0, p});
    end
  endtask : sel

  // pointer after one high-window access, floored at zero
  function automatic logic [1:0] dec(input logic [1:0] p);
    return (p == 2'h0) ? 2'h0 : p - 2'h1;
  endfunction : dec

  // expected config word after a high-window access
  function automatic logic [31:0] cfg_exp(input int k, input logic [1:0] p, input logic u);
    return (k == 0) ? {26'h0, u, 3'h0, dec(p)} : {30'h0, dec(p)};
  endfunction : cfg_exp

  // watchdog: the whole sequence needs roughly 510 cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    fail_count++;
    $display("[ERR] run expected done seen timeout");
    end_sim();
  end

  initial begin
    logic [7:0] cfg, hi, lo;
    mlo = '{'{8'h7f, 8'h3f, 8'h3f, 8'hff}, '{8'h7f, 8'h3f, 8'h3f, 8'h00}};
    mhi = '{'{8'h7f, 8'h07, 8'h1f, 8'h00}, '{8'h7f, 8'h07, 8'h1f, 8'h00}};
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    // control words come out of reset locked, pointers at zero
    xfer(1'b0, `RBR_OFS_CTRL, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0000, rdat)
    xfer(1'b0, `RBR_OFS_ALCFG, 32'h0000_0000);
    `CHK("alcfg reset", 32'h0000_0000, rdat)
    for (int k = 0; k < 2; k++) begin
      cfg = (k == 0) ? `RBR_OFS_CTRL : `RBR_OFS_ALCFG;
      hi = (k == 0) ? `RBR_OFS_TIME_HI : `RBR_OFS_ALARM_HI;
      lo = (k == 0) ? `RBR_OFS_TIME_LO : `RBR_OFS_ALARM_LO;
      // unlocked: all ones into every slot, high access steps pointer
      for (int p = 3; p >= 0; p--) begin
        sel(k, p[1:0], 1'b1);
        xfer(1'b1, lo, 32'h0000_00ff);
        `CHK("low write err", 1'b0, rerr)
        xfer(1'b1, hi, 32'h0000_00ff);
        xfer(1'b0, cfg, 32'h0000_0000);
        `CHK("ptr after write", cfg_exp(k, p[1:0], 1'b1), rdat)
      end
      // locked: zeros must be dropped, pointer still steps
      for (int p = 3; p >= 0; p--) begin
        sel(k, p[1:0], 1'b0);
        xfer(1'b1, lo, 32'h0000_0000);
        xfer(1'b1, hi, 32'h0000_0000);
        `CHK("locked write err", 1'b0, rerr)
        xfer(1'b0, cfg, 32'h0000_0000);
        `CHK("ptr locked", cfg_exp(k, p[1:0], 1'b0), rdat)
      end
      // read back: ones survive only where bits are implemented
      for (int p = 3; p >= 0; p--) begin
        sel(k, p[1:0], 1'b1);
        xfer(1'b0, lo, 32'h0000_0000);
        `CHK("low slot", {24'h0, mlo[k][p]}, rdat)
        xfer(1'b0, hi, 32'h0000_0000);
        `CHK("high slot", {24'h0, mhi[k][p]}, rdat)
        xfer(1'b0, cfg, 32'h0000_0000);
        `CHK("ptr after read", cfg_exp(k, p[1:0], 1'b1), rdat)
      end
    end
    // legal digits land in place: year 42, then locked attempt leaves it
    sel(0, 2'h3, 1'b1);
    xfer(1'b1, `RBR_OFS_TIME_LO, 32'h0000_0042);
    sel(0, 2'h3, 1'b0);
    xfer(1'b1, `RBR_OFS_TIME_LO, 32'h0000_0017);
    xfer(1'b0, `RBR_OFS_TIME_LO, 32'h0000_0000);
    `CHK("year digits", 32'h0000_0042, rdat)
    // unmapped and misaligned places answer with an error
    xfer(1'b0, 8'h18, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rdat)
    xfer(1'b1, 8'h09, 32'h0000_00ff);
    `CHK("misaligned err", 1'b1, rerr)
    // clock enable low stretches a transfer; the write still lands once
    sel(0, 2'h3, 1'b1);
    @(posedge clk_in);
    ce_in <= 1'b0;
    fork
      xfer(1'b1, `RBR_OFS_TIME_LO, 32'h0000_0059);
      begin
        repeat (4) @(posedge clk_in);
        ce_in <= 1'b1;
      end
    join
    xfer(1'b0, `RBR_OFS_TIME_LO, 32'h0000_0000);
    `CHK("year under ce", 32'h0000_0059, rdat)
    // second reset mid-run clears unlock and pointers
    sel(1, 2'h2, 1'b1);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    xfer(1'b0, `RBR_OFS_CTRL, 32'h0000_0000);
    `CHK("ctrl rereset", 32'h0000_0000, rdat)
    xfer(1'b0, `RBR_OFS_ALCFG, 32'h0000_0000);
    `CHK("alcfg rereset", 32'h0000_0000, rdat)
    end_sim();
  end

endmodule : tb_rbr_regs

`default_nettype wire
